// file: core/serial_cfg_pkg.sv
// Register map, field layout and constants of the serial frame block
`default_nettype none
package serial_cfg_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_FRAME = 8'h08;
    localparam logic [7:0] ADDR_BAUD_HI = 8'h0c;
    localparam logic [7:0] ADDR_BAUD_LO = 8'h10;
    localparam logic [7:0] ADDR_DATA = 8'h14;
    // ------------------------------------------------------------
    // Status register bits
    // ------------------------------------------------------------
    localparam int ST_RX_DONE = 7;
    localparam int ST_TX_DONE = 6;
    localparam int ST_TX_READY = 5;
    localparam int ST_FRAME_ERR = 4;
    localparam int ST_PARITY_ERR = 2;
    localparam int ST_DOUBLE = 1;
    // ------------------------------------------------------------
    // Second control register bits
    // ------------------------------------------------------------
    localparam int C2_ENH_RX_STOP = 7;
    localparam int C2_ENHANCED = 6;
    localparam int C2_MANCHESTER = 5;
    localparam int C2_RX_EN = 4;
    localparam int C2_TX_EN = 3;
    localparam int C2_SIZE_HIGH = 2;
    localparam int C2_RX_BIT8 = 1;
    localparam int C2_TX_BIT8 = 0;
    localparam int BAUD_HI_W = 4;
    localparam logic [7:0] FRAME_RESET = 8'h06;
    // ------------------------------------------------------------
    // Parity codes, sizes and oversampling
    // ------------------------------------------------------------
    localparam logic [1:0] PAR_OFF = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;
    localparam logic [2:0] SIZE_NINE_CODE = 3'h7;
    localparam logic [3:0] LEN_BASE = 4'h5;
    localparam logic [3:0] LEN_EIGHT = 4'h8;
    localparam logic [3:0] LEN_NINE = 4'h9;
    localparam logic [3:0] OS_LAST_NORMAL = 4'hf;
    localparam logic [3:0] OS_LAST_DOUBLE = 4'h7;
    localparam logic [3:0] OS_MID_NORMAL = 4'h7;
    localparam logic [3:0] OS_MID_DOUBLE = 4'h3;

    // Frame format control register layout
    typedef struct packed {
        logic reserved;
        logic syncModeSelect;
        logic [1:0] parityModeField;
        logic stopBitSelect;
        logic [1:0] charSizeLowBits;
        logic shiftClockPolarity;
    } frame_fmt_t;

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
    } tx_state_t;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
    } rx_state_t;
endpackage : serial_cfg_pkg
`default_nettype wire

// file: core/serial_frame_core.sv
// Serial transceiver with frame format and baud divisor registers on APB
`default_nettype none
module serial_frame_core (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serialRxPin,
    input wire logic externalShiftClock,
    output logic serialTxPin
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Frame length from the size bits; reserved codes fall back to eight
    function automatic logic [3:0] frameLen(input logic [2:0] code, input logic enh);
        if (enh) begin
            return serial_cfg_pkg::LEN_EIGHT;
        end else if (code == serial_cfg_pkg::SIZE_NINE_CODE) begin
            return serial_cfg_pkg::LEN_NINE;
        end else if (!code[2]) begin
            return serial_cfg_pkg::LEN_BASE + {2'h0, code[1:0]};
        end
        return serial_cfg_pkg::LEN_EIGHT;
    endfunction : frameLen

    // Parity over the first len bits; odd inverts the even result
    function automatic logic parityOf(input logic [8:0] d, input logic [3:0] len,
                                      input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < len) begin
                p = p ^ d[i];
            end
        end
        return p;
    endfunction : parityOf

    // ------------------------------------------------------------
    // Registers and derived configuration
    // ------------------------------------------------------------
    serial_cfg_pkg::frame_fmt_t frame_q;
    serial_cfg_pkg::tx_state_t txState_q;
    serial_cfg_pkg::rx_state_t rxState_q;
    logic [7:0] ctrl2_q;
    logic [3:0] baudHi_q;
    logic [7:0] baudLo_q;
    logic doubleSpeed_q, rxDone_q, txDone_q, frameErr_q, parityErr_q;
    logic [11:0] presCnt_q;
    logic [3:0] txOs_q, rxOs_q, txCnt_q, rxCnt_q;
    logic [8:0] txShift_q, rxShift_q, rxData_q;
    logic txPend_q, txParBit_q, txStop2nd_q, rxStop2nd_q, rxParBit_q, rxFrameBad_q;
    logic [2:0] rxSync_q, clkSync_q;
    logic rxLine_q, rxPrev_q, clkLine_q, clkPrev_q;

    logic [11:0] divisor;
    logic [3:0] charLen, osLast, osMid;
    logic parityOn, parityOdd, enhanced, syncMode;
    logic apbSetup, apbWrite, apbRead, presTick, txStep, rxSample, clkRise, clkFall;

    assign enhanced = ctrl2_q[serial_cfg_pkg::C2_ENHANCED];
    assign syncMode = frame_q.syncModeSelect;
    assign divisor = {baudHi_q, baudLo_q};
    assign charLen = frameLen({ctrl2_q[serial_cfg_pkg::C2_SIZE_HIGH], frame_q.charSizeLowBits},
                              enhanced);
    // Manchester suppresses parity in enhanced mode only; 01 is reserved and treated as off
    assign parityOn = frame_q.parityModeField[1]
                      && !(enhanced && ctrl2_q[serial_cfg_pkg::C2_MANCHESTER]);
    assign parityOdd = (frame_q.parityModeField == serial_cfg_pkg::PAR_ODD);
    // Double speed only matters asynchronously; the polarity bit is assumed zero there
    assign osLast = doubleSpeed_q ? serial_cfg_pkg::OS_LAST_DOUBLE
                                  : serial_cfg_pkg::OS_LAST_NORMAL;
    assign osMid = doubleSpeed_q ? serial_cfg_pkg::OS_MID_DOUBLE : serial_cfg_pkg::OS_MID_NORMAL;

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pready && pwrite;
    assign apbRead = psel && penable && pready && !pwrite;

    // Ready raised for the single access cycle after each setup
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apbSetup;
            pslverr <= apbSetup && !(paddr inside {serial_cfg_pkg::ADDR_STATUS,
                serial_cfg_pkg::ADDR_CTRL2, serial_cfg_pkg::ADDR_FRAME,
                serial_cfg_pkg::ADDR_BAUD_HI, serial_cfg_pkg::ADDR_BAUD_LO,
                serial_cfg_pkg::ADDR_DATA});
        end
    end

    // Read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0;
        end else if (apbSetup && !pwrite) begin
            unique case (paddr)
                serial_cfg_pkg::ADDR_STATUS: prdata <= {24'h0, rxDone_q, txDone_q,
                    txPend_q == 1'b0 && txState_q == serial_cfg_pkg::TX_IDLE, frameErr_q,
                    1'b0, parityErr_q, doubleSpeed_q, 1'b0};
                serial_cfg_pkg::ADDR_CTRL2: prdata <= {24'h0, ctrl2_q[7:2], rxData_q[8],
                    ctrl2_q[0]};
                serial_cfg_pkg::ADDR_FRAME: prdata <= {24'h0, frame_q};
                serial_cfg_pkg::ADDR_BAUD_HI: prdata <= {28'h0, baudHi_q};
                serial_cfg_pkg::ADDR_BAUD_LO: prdata <= {24'h0, baudLo_q};
                serial_cfg_pkg::ADDR_DATA: prdata <= {24'h0, rxData_q[7:0]};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Configuration registers; upper divisor bits are never stored
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            frame_q <= serial_cfg_pkg::FRAME_RESET;
            ctrl2_q <= 8'h0;
            baudHi_q <= 4'h0;
            baudLo_q <= 8'h0;
            doubleSpeed_q <= 1'b0;
        end else if (apbWrite) begin
            unique case (paddr)
                serial_cfg_pkg::ADDR_STATUS: doubleSpeed_q <= pwdata[serial_cfg_pkg::ST_DOUBLE];
                serial_cfg_pkg::ADDR_CTRL2: ctrl2_q <= pwdata[7:0];
                serial_cfg_pkg::ADDR_FRAME: frame_q <= pwdata[7:0];
                serial_cfg_pkg::ADDR_BAUD_HI: baudHi_q <= pwdata[3:0];
                serial_cfg_pkg::ADDR_BAUD_LO: baudLo_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers: three flops, change accepted when last two agree
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rxSync_q <= 3'h7;
            clkSync_q <= 3'h0;
            rxLine_q <= 1'b1;
            rxPrev_q <= 1'b1;
            clkLine_q <= 1'b0;
            clkPrev_q <= 1'b0;
        end else begin
            rxSync_q <= {rxSync_q[1:0], serialRxPin};
            clkSync_q <= {clkSync_q[1:0], externalShiftClock};
            if (rxSync_q[1] == rxSync_q[2]) rxLine_q <= rxSync_q[2];
            if (clkSync_q[1] == clkSync_q[2]) clkLine_q <= clkSync_q[2];
            rxPrev_q <= rxLine_q;
            clkPrev_q <= clkLine_q;
        end
    end

    assign clkRise = clkLine_q && !clkPrev_q;
    assign clkFall = !clkLine_q && clkPrev_q;

    // ------------------------------------------------------------
    // Baud prescaler and oversampling
    // ------------------------------------------------------------
    assign presTick = (presCnt_q == 12'h0);

    // Reload on a low-byte write too, so a new rate starts cleanly
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            presCnt_q <= 12'h0;
        end else if (apbWrite && paddr == serial_cfg_pkg::ADDR_BAUD_LO) begin
            presCnt_q <= {baudHi_q, pwdata[7:0]};
        end else if (presTick) begin
            presCnt_q <= divisor;
        end else begin
            presCnt_q <= presCnt_q - 12'h1;
        end
    end

    // Transmit oversample counter runs freely; a divisor change mid-frame shears bits
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            txOs_q <= 4'h0;
        end else if (presTick) begin
            txOs_q <= (txOs_q >= osLast) ? 4'h0 : txOs_q + 4'h1;
        end
    end

    // Synchronous: change on rising edge at polarity 0, falling at 1
    assign txStep = syncMode ? (frame_q.shiftClockPolarity ? clkFall : clkRise)
                             : (presTick && txOs_q == osLast);
    assign rxSample = syncMode ? (frame_q.shiftClockPolarity ? clkRise : clkFall)
                               : (presTick && rxOs_q == osMid);

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            txPend_q <= 1'b0;
            txShift_q <= 9'h0;
            txParBit_q <= 1'b0;
        end else if (apbWrite && paddr == serial_cfg_pkg::ADDR_DATA
                     && !txPend_q && txState_q == serial_cfg_pkg::TX_IDLE
                     && ctrl2_q[serial_cfg_pkg::C2_TX_EN]) begin
            txPend_q <= 1'b1;
            txShift_q <= {ctrl2_q[serial_cfg_pkg::C2_TX_BIT8], pwdata[7:0]};
            txParBit_q <= parityOf({ctrl2_q[serial_cfg_pkg::C2_TX_BIT8], pwdata[7:0]},
                                   charLen, parityOdd);
        end else if (txStep && txState_q == serial_cfg_pkg::TX_IDLE) begin
            txPend_q <= 1'b0;
        end else if (txStep && txState_q != serial_cfg_pkg::TX_IDLE) begin
            txShift_q <= {1'b0, txShift_q[8:1]};
        end
    end

    // Frame sequencer, one step per bit period
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            txState_q <= serial_cfg_pkg::TX_IDLE;
            serialTxPin <= 1'b1;
            txCnt_q <= 4'h0;
            txStop2nd_q <= 1'b0;
        end else if (txStep) begin
            unique case (txState_q)
                serial_cfg_pkg::TX_IDLE: if (txPend_q) begin
                    txState_q <= serial_cfg_pkg::TX_START;
                    serialTxPin <= 1'b0;
                end
                serial_cfg_pkg::TX_START: begin
                    txState_q <= serial_cfg_pkg::TX_DATA;
                    serialTxPin <= txShift_q[0];
                    txCnt_q <= 4'h1;
                end
                serial_cfg_pkg::TX_DATA: if (txCnt_q >= charLen) begin
                    txState_q <= parityOn ? serial_cfg_pkg::TX_PAR : serial_cfg_pkg::TX_STOP;
                    serialTxPin <= parityOn ? txParBit_q : 1'b1;
                    txStop2nd_q <= 1'b0;
                end else begin
                    serialTxPin <= txShift_q[0];
                    txCnt_q <= txCnt_q + 4'h1;
                end
                serial_cfg_pkg::TX_PAR: begin
                    txState_q <= serial_cfg_pkg::TX_STOP;
                    serialTxPin <= 1'b1;
                    txStop2nd_q <= 1'b0;
                end
                serial_cfg_pkg::TX_STOP: if (frame_q.stopBitSelect && !txStop2nd_q) begin
                    txStop2nd_q <= 1'b1;
                end else begin
                    txState_q <= serial_cfg_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    // Oversample phase restarts at the start edge so samples land mid-bit
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rxOs_q <= 4'h0;
        end else if (rxState_q == serial_cfg_pkg::RX_IDLE) begin
            rxOs_q <= 4'h0;
        end else if (presTick) begin
            rxOs_q <= (rxOs_q >= osLast) ? 4'h0 : rxOs_q + 4'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rxState_q <= serial_cfg_pkg::RX_IDLE;
            rxCnt_q <= 4'h0;
            rxShift_q <= 9'h0;
            rxParBit_q <= 1'b0;
            rxStop2nd_q <= 1'b0;
            rxFrameBad_q <= 1'b0;
        end else if (!ctrl2_q[serial_cfg_pkg::C2_RX_EN]) begin
            rxState_q <= serial_cfg_pkg::RX_IDLE;
        end else begin
            unique case (rxState_q)
                serial_cfg_pkg::RX_IDLE: begin
                    rxCnt_q <= 4'h0;
                    rxShift_q <= 9'h0;
                    rxStop2nd_q <= 1'b0;
                    if (!syncMode && rxPrev_q && !rxLine_q) begin
                        rxState_q <= serial_cfg_pkg::RX_START;
                    end else if (syncMode && rxSample && !rxLine_q) begin
                        rxState_q <= serial_cfg_pkg::RX_DATA;
                    end
                end
                serial_cfg_pkg::RX_START: if (rxSample) begin
                    rxState_q <= rxLine_q ? serial_cfg_pkg::RX_IDLE : serial_cfg_pkg::RX_DATA;
                end
                serial_cfg_pkg::RX_DATA: if (rxSample) begin
                    rxShift_q[rxCnt_q] <= rxLine_q;
                    rxCnt_q <= rxCnt_q + 4'h1;
                    if (rxCnt_q + 4'h1 >= charLen) begin
                        rxState_q <= parityOn ? serial_cfg_pkg::RX_PAR : serial_cfg_pkg::RX_STOP;
                    end
                end
                serial_cfg_pkg::RX_PAR: if (rxSample) begin
                    rxParBit_q <= rxLine_q;
                    rxState_q <= serial_cfg_pkg::RX_STOP;
                end
                serial_cfg_pkg::RX_STOP: if (rxSample) begin
                    // Stop select is ignored; only the enhanced receive-stop bit, with enhanced mode set, adds a second stop
                    if (!rxStop2nd_q) rxFrameBad_q <= !rxLine_q;
                    if (enhanced && ctrl2_q[serial_cfg_pkg::C2_ENH_RX_STOP]
                        && !rxStop2nd_q) begin
                        rxStop2nd_q <= 1'b1;
                    end else begin
                        rxState_q <= serial_cfg_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    logic rxFinish;
    assign rxFinish = rxSample && rxState_q == serial_cfg_pkg::RX_STOP
        && ctrl2_q[serial_cfg_pkg::C2_RX_EN]
        && !(enhanced && ctrl2_q[serial_cfg_pkg::C2_ENH_RX_STOP] && !rxStop2nd_q);

    // Received word and its flags; a new frame wins over a same-cycle clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rxData_q <= 9'h0;
            rxDone_q <= 1'b0;
            frameErr_q <= 1'b0;
            parityErr_q <= 1'b0;
        end else if (rxFinish) begin
            rxData_q <= rxShift_q;
            rxDone_q <= 1'b1;
            frameErr_q <= rxStop2nd_q ? rxFrameBad_q : !rxLine_q;
            parityErr_q <= parityOn
                && (parityOf(rxShift_q, charLen, parityOdd) != rxParBit_q);
        end else if (apbRead && paddr == serial_cfg_pkg::ADDR_DATA) begin
            rxDone_q <= 1'b0;
        end
    end

    // Transmit-complete flag, write one to clear; completion wins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            txDone_q <= 1'b0;
        end else if (txStep && txState_q == serial_cfg_pkg::TX_STOP
                     && !(frame_q.stopBitSelect && !txStop2nd_q)) begin
            txDone_q <= 1'b1;
        end else if (apbWrite && paddr == serial_cfg_pkg::ADDR_STATUS
                     && pwdata[serial_cfg_pkg::ST_TX_DONE]) begin
            txDone_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_baud_reload: assert property (@(posedge mclk) disable iff (!rst_b)
        apbWrite && paddr == serial_cfg_pkg::ADDR_BAUD_LO |=> presCnt_q == divisor)
        else $error("prescaler not reloaded by low divisor write");
    chk_hi_reads_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        apbSetup && !pwrite && paddr == serial_cfg_pkg::ADDR_BAUD_HI |=> prdata[31:4] == 28'h0)
        else $error("reserved divisor bits read nonzero");
    chk_parity_bit: assert property (@(posedge mclk) disable iff (!rst_b)
        txState_q == serial_cfg_pkg::TX_PAR |-> serialTxPin == txParBit_q && parityOn)
        else $error("parity bit wrong on line");
    chk_stop_high: assert property (@(posedge mclk) disable iff (!rst_b)
        txState_q == serial_cfg_pkg::TX_STOP |-> serialTxPin)
        else $error("stop bit not high");
    chk_two_stops: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(txStop2nd_q) |-> frame_q.stopBitSelect && txState_q == serial_cfg_pkg::TX_STOP)
        else $error("second stop without two-stop select");
    chk_enh_length: assert property (@(posedge mclk) disable iff (!rst_b)
        enhanced |-> charLen == serial_cfg_pkg::LEN_EIGHT)
        else $error("size bits affected enhanced frame length");
    chk_parity_flag: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(parityErr_q) |-> $past(parityOn && rxState_q == serial_cfg_pkg::RX_STOP))
        else $error("parity error flag without checked frame");
    chk_sync_edge: assert property (@(posedge mclk) disable iff (!rst_b)
        syncMode && $past(syncMode) && $changed(txState_q)
        |-> $past(frame_q.shiftClockPolarity ? clkFall : clkRise))
        else $error("transmit moved on the wrong shift clock edge");
    chk_async_rate: assert property (@(posedge mclk) disable iff (!rst_b)
        !syncMode && $past(!syncMode) && $changed(txState_q)
        |-> $past(presTick && txOs_q == osLast))
        else $error("transmit moved off the oversampled bit boundary");
endmodule : serial_frame_core
`default_nettype wire

// file: sim/remote_serial.sv
// Far-side serial transceiver model
`default_nettype none
module remote_serial (
    input wire logic mclk,
    input wire logic txLine,
    output logic rxLine,
    output logic shiftClk
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rxLine = 1'b1;
    // Shift clock stands low between frames
    initial shiftClk = 1'b0;
    // Drive LSB first, one bit per period, then idle high
    task automatic sendBits(input logic [11:0] b, input int n, input int per);
        for (int i = 0; i < n * per; i++) begin
            @(posedge mclk);
            rxLine <= b[i / per];
        end
        @(posedge mclk);
        rxLine <= 1'b1;
    endtask : sendBits
    // Bounded wait for start edge, then mid-bit samples
    task automatic grabBits(input int per, output logic [11:0] b);
        for (int i = 0; i < 900 && txLine; i++) @(posedge mclk);
        repeat (per / 2) @(posedge mclk);
        for (int i = 0; i < 12; i++) begin
            b[i] = txLine;
            repeat (per) @(posedge mclk);
        end
    endtask : grabBits
    // Synchronous link, polarity 0: raise the clock, sample just before it falls
    task automatic clockBits(input int per, output logic [11:0] b);
        for (int i = 0; i < 12; i++) begin
            repeat (per / 2) @(posedge mclk);
            shiftClk <= 1'b1;
            repeat (per / 2) @(posedge mclk);
            b[i] = txLine;
            shiftClk <= 1'b0;
        end
    endtask : clockBits
endmodule : remote_serial
`default_nettype wire

// file: sim/serial_frame_format_and_baud_config_tb.sv
// Self-checking bench for the serial frame block
`default_nettype none
module serial_frame_format_and_baud_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, rxLine, txLine, shiftClk;
    logic [11:0] got;
    logic [7:0] tf[5] = '{8'h04, 8'h16, 8'h2e, 8'h30, 8'h06};
    logic [7:0] td[5] = '{8'h5a, 8'hc3, 8'ha5, 8'h13, 8'h81};
    logic [7:0] rowDiv[5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
    logic rowDbl[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    // Bit period: 16 (8 at double speed) times divisor plus one
    int rowPer[5] = '{16, 16, 16, 32, 16};
    int failures = 0, num_checks = 0, cycles = 0;
    always #50 mclk = ~mclk;
    serial_frame_core uut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serialRxPin(rxLine), .externalShiftClock(shiftClk),
        .serialTxPin(txLine));
    remote_serial far (.mclk(mclk), .txLine(txLine), .rxLine(rxLine), .shiftClk(shiftClk));
    task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", w, e, s);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    // One APB transfer; a free edge first so psel never toggles in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Expected line bits: start, data LSB first, parity, idle-high stops
    function automatic logic [11:0] expBits(input logic [7:0] f, input logic [7:0] d);
        int n;
        expBits = 12'hffe;
        n = 5 + f[2:1];
        for (int i = 0; i < n; i++) expBits[i + 1] = d[i];
        if (f[5]) expBits[n + 1] = ^(d & ~(8'hff << n)) ^ f[4];
    endfunction : expBits
    // Hang guard, long enough for every frame below
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        apb(1'b1, serial_cfg_pkg::ADDR_CTRL2, 32'h18);
        // Each parity code, sizes of 5, 7 and 8 bits; divisor 1 gives 32-cycle bits, 16 at double speed
        for (int r = 0; r < 5; r++) begin
            apb(1'b1, serial_cfg_pkg::ADDR_STATUS, {30'h0, rowDbl[r], 1'b0});
            apb(1'b1, serial_cfg_pkg::ADDR_FRAME, {24'h0, tf[r]});
            apb(1'b1, serial_cfg_pkg::ADDR_BAUD_LO, {24'h0, rowDiv[r]});
            fork
                far.grabBits(rowPer[r], got);
                apb(1'b1, serial_cfg_pkg::ADDR_DATA, {24'h0, td[r]});
            join
            check("txFrame", got, expBits(tf[r], td[r]));
        end
        // Even parity, 8 bits, 16-cycle bits at double speed; parity bit sent wrong
        apb(1'b1, serial_cfg_pkg::ADDR_FRAME, 32'h2e);
        far.sendBits({2'b11, 8'h3c, 1'b0}, 11, 16);
        repeat (40) @(posedge mclk);
        apb(1'b0, serial_cfg_pkg::ADDR_STATUS, 32'h0);
        check("parityErr", rd[serial_cfg_pkg::ST_PARITY_ERR], 1'b1);
        apb(1'b0, serial_cfg_pkg::ADDR_DATA, 32'h0);
        check("rxData", rd[7:0], 8'h3c);
        // Synchronous frame clocked by the far side; double speed off there
        apb(1'b1, serial_cfg_pkg::ADDR_STATUS, 32'h0);
        apb(1'b1, serial_cfg_pkg::ADDR_FRAME, 32'h46);
        apb(1'b1, serial_cfg_pkg::ADDR_DATA, 32'ha5);
        far.clockBits(16, got);
        check("syncFrame", got, expBits(8'h46, 8'ha5));
        apb(1'b1, serial_cfg_pkg::ADDR_BAUD_HI, 32'h0a);
        apb(1'b0, serial_cfg_pkg::ADDR_BAUD_HI, 32'h0);
        check("baudHigh", rd, 32'h0a);
        apb(1'b0, 8'h3c, 32'h0);
        check("unmapped", rd, 32'h0);
        check("slaveErr", err, 1'b1);
        // Mid-run reset restores the register defaults
        rst_b <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        apb(1'b0, serial_cfg_pkg::ADDR_FRAME, 32'h0);
        check("frameReset", rd, {24'h0, serial_cfg_pkg::FRAME_RESET});
        apb(1'b0, serial_cfg_pkg::ADDR_BAUD_HI, 32'h0);
        check("baudReset", rd, 32'h0);
        end_sim();
    end
endmodule : serial_frame_format_and_baud_config_tb
`default_nettype wire
